/* scec_pkg.sv */
// Purpose: shared constants and types for the scanner command execution control block
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes:   register offsets and opcode values are local assignments
package scec_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_RESP     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_ERROR    = 8'h0c;
  localparam logic [7:0] ADDR_SETTINGS = 8'h10;
  localparam logic [7:0] ADDR_LIMITS   = 8'h14;

  // ==========================================================================
  // command opcodes, carried in cmd word bits 31:24
  localparam logic [7:0] OP_SET_TERM   = 8'h01; // deferred
  localparam logic [7:0] OP_SET_WEIGHT = 8'h02; // deferred
  localparam logic [7:0] OP_CFG_CHANS  = 8'h03; // deferred
  localparam logic [7:0] OP_CLR_CHANS  = 8'h04; // immediate
  localparam logic [7:0] OP_EXECUTE    = 8'h10; // immediate
  localparam logic [7:0] OP_QRY_TERM   = 8'h20; // immediate
  localparam logic [7:0] OP_QRY_WEIGHT = 8'h21; // immediate
  localparam logic [7:0] OP_QRY_HLL    = 8'h22; // immediate, needs channels
  localparam logic [7:0] OP_CALIBRATE  = 8'h30; // immediate
  localparam logic [7:0] OP_LINE_END   = 8'hff; // end of command line

  // ==========================================================================
  // status byte and error code bits
  localparam int         STB_READY_BIT = 3;
  localparam int         STB_RESP_BIT  = 4;
  localparam int         ERR_CONFLICT  = 7;  // code 128
  localparam int         ERR_CAL       = 2;  // code 4
  localparam int         ERR_INVALID   = 0;  // code 1

  // ==========================================================================
  // value ranges, reset values and weight limits
  localparam logic [15:0] TERM_MAX      = 16'h00ff;
  localparam logic [7:0]  TERM_RST      = 8'h0d;
  localparam logic [8:0]  WEIGHT_RST    = 9'h020;
  localparam logic [8:0]  WEIGHT_W64    = 9'h040;
  localparam logic [8:0]  WEIGHT_W128   = 9'h080;
  localparam logic [8:0]  WEIGHT_W256   = 9'h100;
  localparam logic [9:0]  LIMIT_BASE    = 10'h2e8; // 744
  localparam logic [9:0]  LIMIT_W64     = 10'h1af; // 431
  localparam logic [9:0]  LIMIT_W128    = 10'h0ea; // 234
  localparam logic [9:0]  LIMIT_W256    = 10'h07a; // 122
  localparam logic [3:0]  SAMPLES_LINE  = 4'h5;    // log2 of 32 per line cycle
  localparam logic [7:0]  RATE_DEFAULT  = 8'h2c;   // 44 channels per second

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_BUSY  = 2'b10
  } scec_state_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  rsvd;
    logic [15:0] arg;
  } scec_cmd_t;

endpackage

/* scec_top.sv */
// Purpose: deferred/immediate command handling, user terminator and averaging weight
// Assumes: commands arrive pre-tokenised as words written to the command register
// Notes:   one response slot; reading the response register empties it
`timescale 1ns/1ps

// Operation
// [RL1] store terminator code; accept 0 through 255 on execute
// [RL2] stored terminator drives response terminator and reading separator outputs
// [RL3] terminator query returns current stored value
// [RL4] weight accepts 1..256 powers of two only; defaults to 32
// [RL5] weight sets sample count for averaging or rms computation
// [RL6] weights 64, 128, 256 mean 2, 4, 8 line cycles of 32
// [RL7] channel limit by weight: 744, 431, 234, 122
// [RL8] default weight in line mode gives up to 44 channels per second
// [RL9] host uses weight of 32 or more for ac volts
// [RL10] deferred commands parsed on arrival, applied only on execute
// [RL11] host follows each system command with its own execute
// [RL12] every execute in a line acts
// [RL13] immediate commands act at once
// [RL14] front panel outputs frozen while a line is interpreted
// [RL15] ready shown in status byte bit 3
// [RL16] channel-needing immediate before pending config executes: error 128, error lamp
// [RL17] query responses made at once, fixed format, held until read
// [RL18] status read clears errors except calibration error
// [RL19] out-of-range terminator or weight rejected, old kept, invalid flagged
module scec_top
  import scec_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  input  wire logic              cal_fail,
  output logic      [DATA_W-1:0] rdata,
  output logic      [7:0]        term_char,
  output logic      [8:0]        weight_value,
  output logic      [3:0]        line_cycles,
  output logic      [9:0]        max_chans,
  output logic      [9:0]        active_chans,
  output logic      [7:0]        max_rate,
  output logic                   ready,
  output logic                   led_error,
  output logic                   led_ready
);

  // ==========================================================================
  // decode helpers
  function automatic logic wt_ok(input logic [15:0] w);
    return (w != 16'h0000) && (w <= 16'h0100) && ((w & (w - 16'h0001)) == 16'h0000);
  endfunction

  function automatic logic [9:0] wt_limit(input logic [8:0] w);
    case (w)
      WEIGHT_W64:  return LIMIT_W64;
      WEIGHT_W128: return LIMIT_W128;
      WEIGHT_W256: return LIMIT_W256;
      default:     return LIMIT_BASE;
    endcase
  endfunction

  function automatic logic [3:0] wt_cycles(input logic [8:0] w);
    case (w)
      WEIGHT_W64:  return 4'h2;
      WEIGHT_W128: return 4'h4;
      WEIGHT_W256: return 4'h8;
      default:     return 4'h1;
    endcase
  endfunction

  // ==========================================================================
  // bus decode
  scec_cmd_t   cmd;
  logic        cmd_wr;
  logic        is_exec;
  logic        is_line_end;
  logic        hll_conflict;
  logic        err_rd;
  logic        resp_rd;

  assign cmd          = scec_cmd_t'(wdata);
  assign cmd_wr       = wr_stb && (addr == ADDR_CMD);
  assign is_exec      = cmd_wr && (cmd.op == OP_EXECUTE);
  assign is_line_end  = cmd_wr && (cmd.op == OP_LINE_END);
  assign err_rd       = rd_stb && (addr == ADDR_ERROR);
  assign resp_rd      = rd_stb && (addr == ADDR_RESP);

  // ==========================================================================
  // interpretation state
  scec_state_t state_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_READY;
    end else begin
      case (state_r)
        ST_READY: if (cmd_wr && !is_line_end) begin
          state_r <= ST_BUSY;
        end
        ST_BUSY: if (is_line_end) begin
          state_r <= ST_READY;
        end
        default: state_r <= ST_READY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b1;
    end else begin
      ready <= (state_r == ST_BUSY) ? is_line_end : !(cmd_wr && !is_line_end); // RL15
    end
  end

  // ==========================================================================
  // deferred settings: parsed now, held pending until execute
  logic        pend_term_v_r;
  logic [7:0]  pend_term_r;
  logic        pend_wt_v_r;
  logic [8:0]  pend_wt_r;
  logic        pend_chan_v_r;
  logic [9:0]  pend_chan_r;
  logic [8:0]  wt_eff;
  logic        bad_term;
  logic        bad_wt;
  logic        bad_chan;

  // terminator and weight checks happen at parse time so a bad value never reaches pending; the channel limit is checked on execute
  assign bad_term = cmd_wr && (cmd.op == OP_SET_TERM) && (cmd.arg > TERM_MAX);        // RL19
  assign bad_wt   = cmd_wr && (cmd.op == OP_SET_WEIGHT) && !wt_ok(cmd.arg);           // RL19
  assign wt_eff   = pend_wt_v_r ? pend_wt_r : weight_value;
  assign bad_chan = is_exec && pend_chan_v_r && (pend_chan_r > wt_limit(wt_eff));     // RL7

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_term_v_r <= 1'b0;
      pend_term_r   <= 8'h00;
    end else if (cmd_wr && (cmd.op == OP_SET_TERM) && !bad_term) begin
      pend_term_v_r <= 1'b1;                                                          // RL10
      pend_term_r   <= cmd.arg[7:0];
    end else if (is_exec) begin
      pend_term_v_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_wt_v_r <= 1'b0;
      pend_wt_r   <= WEIGHT_RST;
    end else if (cmd_wr && (cmd.op == OP_SET_WEIGHT) && !bad_wt) begin
      pend_wt_v_r <= 1'b1;                                                            // RL10
      pend_wt_r   <= cmd.arg[8:0];
    end else if (is_exec) begin
      pend_wt_v_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_chan_v_r <= 1'b0;
      pend_chan_r   <= 10'h000;
    end else if (cmd_wr && (cmd.op == OP_CFG_CHANS)) begin
      pend_chan_v_r <= 1'b1;                                                          // RL10
      pend_chan_r   <= cmd.arg[9:0];
    end else if (is_exec || (cmd_wr && (cmd.op == OP_CLR_CHANS))) begin
      pend_chan_v_r <= 1'b0;
    end
  end

  // ==========================================================================
  // live settings, updated on every execute in the line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term_char <= TERM_RST;
    end else if (is_exec && pend_term_v_r) begin
      term_char <= pend_term_r;                                                       // RL1 RL2 RL12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      weight_value <= WEIGHT_RST;                                                     // RL4
      line_cycles  <= 4'h1;
      max_chans    <= LIMIT_BASE;
    end else if (is_exec && pend_wt_v_r) begin
      weight_value <= pend_wt_r;                                                      // RL5 RL12
      line_cycles  <= wt_cycles(pend_wt_r);                                           // RL6
      max_chans    <= wt_limit(pend_wt_r);                                            // RL7
    end
  end

  // a config that would overrun the limit is dropped whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_chans <= 10'h000;
    end else if (cmd_wr && (cmd.op == OP_CLR_CHANS)) begin
      active_chans <= 10'h000;                                                        // RL13
    end else if (is_exec && pend_chan_v_r && !bad_chan) begin
      active_chans <= pend_chan_r;                                                    // RL7
    end
  end

  // rate figure only holds for the default weight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      max_rate <= RATE_DEFAULT;
    end else begin
      max_rate <= (weight_value == WEIGHT_RST) ? RATE_DEFAULT : 8'h00;                // RL8
    end
  end

  // ==========================================================================
  // immediate query responses, one fixed-format slot
  logic        resp_v_r;
  logic [31:0] resp_r;

  assign hll_conflict = cmd_wr && (cmd.op == OP_QRY_HLL) && (pend_chan_v_r || (active_chans == 10'h000));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_v_r <= 1'b0;
      resp_r   <= 32'h0000_0000;
    end else if (cmd_wr && (cmd.op == OP_QRY_TERM)) begin
      resp_v_r <= 1'b1;                                                               // RL17
      resp_r   <= {OP_QRY_TERM, 16'h0000, term_char};                                 // RL3
    end else if (cmd_wr && (cmd.op == OP_QRY_WEIGHT)) begin
      resp_v_r <= 1'b1;                                                               // RL17
      resp_r   <= {OP_QRY_WEIGHT, 15'h0000, weight_value};
    end else if (cmd_wr && (cmd.op == OP_QRY_HLL) && !hll_conflict) begin
      resp_v_r <= 1'b1;                                                               // RL13
      resp_r   <= {OP_QRY_HLL, 14'h0000, active_chans};
    end else if (resp_rd) begin
      resp_v_r <= 1'b0;
    end
  end

  // ==========================================================================
  // error code: new events beat a same-cycle read clear
  logic [7:0] err_r;
  logic       bad_op;

  assign bad_op = cmd_wr && !(cmd.op inside {OP_SET_TERM, OP_SET_WEIGHT, OP_CFG_CHANS, OP_CLR_CHANS,
                                             OP_EXECUTE, OP_QRY_TERM, OP_QRY_WEIGHT, OP_QRY_HLL,
                                             OP_CALIBRATE, OP_LINE_END});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= 8'h00;
    end else begin
      if (err_rd) begin
        err_r[ERR_CONFLICT] <= 1'b0;                                                  // RL18
        err_r[ERR_INVALID]  <= 1'b0;                                                  // RL18
      end
      if (hll_conflict) begin
        err_r[ERR_CONFLICT] <= 1'b1;                                                  // RL16
      end
      if (bad_term || bad_wt || bad_chan || bad_op) begin
        err_r[ERR_INVALID] <= 1'b1;                                                   // RL19
      end
      // calibration fault survives status reads, only recalibration clears it
      if (cmd_wr && (cmd.op == OP_CALIBRATE)) begin
        err_r[ERR_CAL] <= 1'b0;
      end
      if (cal_fail) begin
        err_r[ERR_CAL] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // front panel: sampled only while ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_error <= 1'b0;
      led_ready <= 1'b1;
    end else if (state_r == ST_READY) begin
      led_error <= (err_r != 8'h00);                                                  // RL14 RL16
      led_ready <= ready;                                                             // RL14
    end
  end

  // ==========================================================================
  // read port: data stand in the cycle after the strobe only
  logic [7:0] status_byte;

  always_comb begin
    status_byte                = 8'h00;
    status_byte[STB_READY_BIT] = (state_r == ST_READY);                               // RL15
    status_byte[STB_RESP_BIT]  = resp_v_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd_stb) begin
      case (addr)
        ADDR_RESP:     rdata <= DATA_W'(resp_v_r ? resp_r : 32'h0000_0000);
        ADDR_STATUS:   rdata <= DATA_W'(status_byte);
        ADDR_ERROR:    rdata <= DATA_W'(err_r);
        ADDR_SETTINGS: rdata <= DATA_W'({7'h00, weight_value, 4'h0, line_cycles, term_char});
        ADDR_LIMITS:   rdata <= DATA_W'({max_rate, 2'h0, active_chans, 2'h0, max_chans});
        default:       rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule // scec_top

/* scec_top_assertions.sv */
// Purpose: port-level checks for scec_top
// Assumes: default 8-bit address and 32-bit data widths
// Notes:   bound into every scec_top instance
`timescale 1ns/1ps
module scec_top_assertions
  import scec_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  term_char,
  input wire logic [8:0]  weight_value,
  input wire logic [3:0]  line_cycles,
  input wire logic [9:0]  max_chans,
  input wire logic [7:0]  max_rate,
  input wire logic        ready,
  input wire logic        led_error,
  input wire logic        led_ready
);
  // ==========================================================================
  // helpers
  logic       cmd_wr;
  logic       exec_hit;
  logic [7:0] op;
  logic [9:0] lim_exp;
  assign cmd_wr   = wr_stb && addr == ADDR_CMD;
  assign op       = wdata[31:24];
  assign exec_hit = cmd_wr && op == OP_EXECUTE;
  assign lim_exp  = weight_value == WEIGHT_W256 ? LIMIT_W256 :
                    weight_value == WEIGHT_W128 ? LIMIT_W128 :
                    weight_value == WEIGHT_W64  ? LIMIT_W64  : LIMIT_BASE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // properties
  property p_ready_drop; cmd_wr && op != OP_LINE_END |=> !ready; endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready high in line");
  property p_ready_back; cmd_wr && op == OP_LINE_END |=> ready; endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready low after line end");
  property p_led_hold; !ready |=> $stable(led_error) && $stable(led_ready); endproperty
  a_led_hold: assert property (p_led_hold) else $error("lamp moved while busy");
  property p_exec_only; $changed(term_char) || $changed(weight_value) |-> $past(exec_hit); endproperty
  a_exec_only: assert property (p_exec_only) else $error("setting moved without execute");
  property p_onehot; $onehot(weight_value); endproperty
  a_onehot: assert property (p_onehot) else $error("illegal weight");
  property p_cycles; line_cycles == (weight_value > WEIGHT_RST ? weight_value[8:5] : 4'h1); endproperty
  a_cycles: assert property (p_cycles) else $error("line cycles wrong");
  property p_limit; max_chans == lim_exp; endproperty
  a_limit: assert property (p_limit) else $error("channel limit wrong");
  property p_rate; max_rate == ($past(weight_value) == WEIGHT_RST ? RATE_DEFAULT : 8'h00); endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");
  property p_status; rd_stb && addr == ADDR_STATUS |=> rdata[STB_READY_BIT] == $past(ready); endproperty
  a_status: assert property (p_status) else $error("status ready bit wrong");
  property p_qterm; cmd_wr && op == OP_QRY_TERM ##1 rd_stb && addr == ADDR_RESP |=> rdata[7:0] == $past(term_char); endproperty
  a_qterm: assert property (p_qterm) else $error("terminator query wrong");
  property p_rd_zero; !$past(rd_stb) |-> rdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
endmodule // scec_top_assertions

bind scec_top scec_top_assertions i_scec_top_assertions (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .term_char(term_char), .weight_value(weight_value), .line_cycles(line_cycles),
  .max_chans(max_chans), .max_rate(max_rate), .ready(ready), .led_error(led_error), .led_ready(led_ready)
);

/* scec_host.sv */
// Purpose: bus controller model issuing command words over the register port
// Assumes: tasks are entered just after a rising clock edge
// Notes:   a write leaves its strobe up so writes and reads can follow with no gap
`timescale 1ns/1ps
module scec_host
  import scec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr_stb,
  output logic             rd_stb
);
  initial begin
    addr   = 8'h00;
    wdata  = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // ==========================================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
  endtask
  task automatic idle();
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  // ==========================================================================
  // command helpers
  task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
    wr(ADDR_CMD, {op, 8'h00, arg});
  endtask
  task automatic apply(input logic [7:0] op, input logic [15:0] arg);
    cmd(op, arg);
    cmd(OP_EXECUTE, 16'h0000);
    idle();
  endtask
  // bounded poll so a stuck busy flag cannot hang the run
  task automatic poll_ready(output logic ok);
    logic [31:0] s;
    ok = 1'b0;
    for (int i = 0; i < 16 && ok !== 1'b1; i++) begin
      rd(ADDR_STATUS, s);
      ok = s[STB_READY_BIT];
    end
  endtask
endmodule // scec_host

/* scec_top_tb.sv */
// Purpose: self-checking bench for scec_top
// Assumes: scec_host drives the register port
// Notes:   expectations come from the weight table and the opcode set
`timescale 1ns/1ps
module scec_top_tb
  import scec_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cal_fail = 1'b0;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  term_char;
  logic [7:0]  max_rate;
  logic [8:0]  weight_value;
  logic [3:0]  line_cycles;
  logic [9:0]  max_chans;
  logic [9:0]  active_chans;
  logic        ready;
  logic        led_error;
  logic        led_ready;
  logic        ok;
  logic [31:0] d;
  logic [9:0]  lim [9] = '{10'h2e8, 10'h2e8, 10'h2e8, 10'h2e8, 10'h2e8, 10'h2e8, 10'h1af, 10'h0ea, 10'h07a};
  int          fails = 0;
  int          check_count = 0;
  always #5 clk = ~clk;

  scec_host i_scec_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
  scec_top i_scec_top (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .cal_fail(cal_fail), .rdata(rdata), .term_char(term_char), .weight_value(weight_value),
    .line_cycles(line_cycles), .max_chans(max_chans), .active_chans(active_chans), .max_rate(max_rate),
    .ready(ready), .led_error(led_error), .led_ready(led_ready)
  );
  // ==========================================================================
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic setv(input logic [7:0] op, input logic [15:0] arg);
    i_scec_host.apply(op, arg);
    #1;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    i_scec_host.rd(a, d);
    check(name, d, exp);
  endtask
  task automatic check_defaults();
    rd_chk("settings", ADDR_SETTINGS, 32'h0020010d);
    rd_chk("limits", ADDR_LIMITS, 32'h2c0002e8);
    check("ready", 32'(ready), 32'h1);
  endtask
  // ==========================================================================
  // tests
  initial begin
    do_reset();
    check_defaults();
    i_scec_host.cmd(OP_SET_TERM, 16'h002c);
    i_scec_host.idle();
    #1;
    check("busy", 32'(ready), 32'h0);
    check("term held", 32'(term_char), 32'h0d);
    setv(OP_EXECUTE, 16'h0000);
    check("term", 32'(term_char), 32'h2c);
    i_scec_host.cmd(OP_QRY_TERM, 16'h0000);
    rd_chk("resp", ADDR_RESP, 32'h2000002c);
    i_scec_host.cmd(OP_LINE_END, 16'h0000);
    i_scec_host.poll_ready(ok);
    check("poll", 32'(ok), 32'h1);
    setv(OP_SET_TERM, 16'h0000);
    check("term min", 32'(term_char), 32'h00);
    setv(OP_SET_TERM, 16'h00ff);
    check("term max", 32'(term_char), 32'hff);
    setv(OP_SET_TERM, 16'h0100);
    check("term kept", 32'(term_char), 32'hff);
    rd_chk("err inv", ADDR_ERROR, 32'h1);
    for (int i = 0; i < 9; i++) begin
      setv(OP_SET_WEIGHT, 16'(1 << i));
      @(posedge clk);
      #1;
      check("weight", 32'(weight_value), 32'(1 << i));
      check("cycles", 32'(line_cycles), (i > 5) ? 32'(1 << (i - 5)) : 32'h1);
      check("limit", 32'(max_chans), 32'(lim[i]));
      check("rate", 32'(max_rate), (i == 5) ? 32'h2c : 32'h0);
    end
    setv(OP_SET_WEIGHT, 16'h0003);
    check("weight kept", 32'(weight_value), 32'h100);
    i_scec_host.cmd(OP_QRY_WEIGHT, 16'h0000);
    rd_chk("qry weight", ADDR_RESP, 32'h21000100);
    setv(OP_CFG_CHANS, 16'h007b);
    check("over limit", 32'(active_chans), 32'h0);
    setv(OP_CFG_CHANS, 16'h007a);
    check("at limit", 32'(active_chans), 32'h7a);
    rd_chk("err lim", ADDR_ERROR, 32'h1);
    rd_chk("err clr", ADDR_ERROR, 32'h0);
    i_scec_host.cmd(OP_CLR_CHANS, 16'h0000);
    i_scec_host.idle();
    #1;
    check("cleared", 32'(active_chans), 32'h0);
    i_scec_host.cmd(OP_CFG_CHANS, 16'h0003);
    i_scec_host.cmd(OP_QRY_HLL, 16'h0000);
    i_scec_host.cmd(OP_EXECUTE, 16'h0000);
    #1;
    check("lamp frozen", 32'(led_error), 32'h0);
    i_scec_host.cmd(OP_LINE_END, 16'h0000);
    i_scec_host.poll_ready(ok);
    check("chans", 32'(active_chans), 32'h3);
    check("lamp", 32'(led_error), 32'h1);
    check("lamp ready", 32'(led_ready), 32'h1);
    rd_chk("no resp", ADDR_RESP, 32'h0);
    rd_chk("conflict", ADDR_ERROR, 32'h80);
    rd_chk("conf clr", ADDR_ERROR, 32'h0);
    i_scec_host.cmd(OP_QRY_HLL, 16'h0000);
    rd_chk("resp flag", ADDR_STATUS, 32'h10);
    rd_chk("hll", ADDR_RESP, 32'h22000003);
    @(posedge clk);
    cal_fail <= 1'b1;
    @(posedge clk);
    cal_fail <= 1'b0;
    rd_chk("cal", ADDR_ERROR, 32'h4);
    rd_chk("cal kept", ADDR_ERROR, 32'h4);
    i_scec_host.cmd(OP_CALIBRATE, 16'h0000);
    rd_chk("cal clr", ADDR_ERROR, 32'h0);
    i_scec_host.cmd(8'h55, 16'h0000);
    rd_chk("bad op", ADDR_ERROR, 32'h1);
    rd_chk("unmapped", 8'h3c, 32'h0);
    do_reset();
    i_scec_host.wr(8'h3c, 32'hffffffff);
    check_defaults();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule // scec_top_tb
